// ---- sscf_pkg.sv ----
`default_nettype none
package sscf_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] STATUS_OFFSET = 12'h804;
    localparam logic [11:0] CONFIG_OFFSET = 12'h805;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    localparam logic [3:0] RESERVED_BITS_VALUE = 4'h0;
    localparam logic [3:0] CLEAR_ALL = 4'hf;
    localparam logic [3:0] CLEAR_NONE = 4'h0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CARD_DETECT_BIT = 3;
    localparam int READY_BIT = 2;
    localparam int BATTERY_LOW_BIT = 1;
    localparam int BATTERY_DEAD_BIT = 0;
    localparam int ROUTE_LSB = 4;
    localparam int SOURCE_MSB = 3;
    localparam logic [3:0] ROUTE_NONE = 4'h0;
    localparam logic SOCKET_CARD_MEMORY = 1'b0;
    localparam logic SOCKET_CARD_IO = 1'b1;

    typedef struct packed {
        logic [3:0] status_irq_route_select;
        logic card_detect_irq_enable;
        logic ready_irq_enable;
        logic battery_low_irq_enable;
        logic battery_dead_irq_enable;
    } sscf_config_t;

    typedef struct packed {
        logic card_detect_changed;
        logic ready_rise_flag;
        logic battery_low_flag;
        logic battery_dead_flag;
    } sscf_flags_t;

    typedef struct packed {
        sscf_config_t cfg;
        sscf_flags_t flags;
        logic cd_a_prev;
        logic cd_b_prev;
        logic ready_prev;
        logic primed;
        logic [7:0] rdata;
        logic irq;
    } sscf_state_t;
endpackage
`default_nettype wire

// ---- sscf_socket_status_change_flags.sv ----
`default_nettype none
module sscf_socket_status_change_flags (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [sscf_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_flag_clear_on_write,
    input wire logic i_socket_card_kind,
    input wire logic i_ring_function_enable,
    input wire logic i_card_detect_line_a,
    input wire logic i_card_detect_line_b,
    input wire logic i_ready_line,
    input wire logic i_battery_low_line,
    input wire logic i_card_status_change_pin,
    input wire logic i_ring_indicate_line,
    output logic [7:0] o_reg_rdata,
    output logic o_socket_status_event,
    output logic [3:0] o_status_irq_route_select
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // flags as software sees them: masked by enables and card kind
    function automatic logic [3:0] visible(input sscf_pkg::sscf_flags_t f,
                                           input sscf_pkg::sscf_config_t c,
                                           input logic io);
        logic [3:0] kind_mask;
        kind_mask = 4'hf;
        if (io == sscf_pkg::SOCKET_CARD_IO) begin
            kind_mask[sscf_pkg::READY_BIT] = 1'b0;
            kind_mask[sscf_pkg::BATTERY_LOW_BIT] = 1'b0;
        end
        visible = f & c[sscf_pkg::SOURCE_MSB:0] & kind_mask;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sscf_pkg::sscf_state_t st_reg;
    sscf_pkg::sscf_state_t st_next;
    logic status_rd;
    logic status_wr;
    logic config_rd;
    logic config_wr;
    logic is_io;
    logic [3:0] events;
    logic [3:0] clr;
    logic [3:0] held;

    always_comb begin
        st_next = st_reg;
        status_rd = i_reg_rd && (i_reg_addr == sscf_pkg::STATUS_OFFSET);
        status_wr = i_reg_wr && (i_reg_addr == sscf_pkg::STATUS_OFFSET);
        config_rd = i_reg_rd && (i_reg_addr == sscf_pkg::CONFIG_OFFSET);
        config_wr = i_reg_wr && (i_reg_addr == sscf_pkg::CONFIG_OFFSET);
        is_io = (i_socket_card_kind == sscf_pkg::SOCKET_CARD_IO);
        // edges wait one sample after reset so the first look is not a change
        events[sscf_pkg::CARD_DETECT_BIT] = st_reg.primed &&
            ((i_card_detect_line_a != st_reg.cd_a_prev) ||
             (i_card_detect_line_b != st_reg.cd_b_prev));
        events[sscf_pkg::READY_BIT] = st_reg.primed && !is_io &&
            i_ready_line && !st_reg.ready_prev;
        events[sscf_pkg::BATTERY_LOW_BIT] = !is_io && i_battery_low_line;
        events[sscf_pkg::BATTERY_DEAD_BIT] = i_card_status_change_pin;
        events = events & st_reg.cfg[sscf_pkg::SOURCE_MSB:0];
        clr = sscf_pkg::CLEAR_NONE;
        if (status_rd && !i_flag_clear_on_write) begin
            clr = sscf_pkg::CLEAR_ALL;
        end
        if (status_wr && i_flag_clear_on_write) begin
            clr = i_reg_wdata[sscf_pkg::SOURCE_MSB:0];
        end
        // set wins over a clear in the same cycle
        held = (st_reg.flags & ~clr) | events;
        if (i_ring_function_enable) begin
            held[sscf_pkg::BATTERY_DEAD_BIT] = i_ring_indicate_line &&
                st_reg.cfg.battery_dead_irq_enable;
        end
        st_next.flags = held;
        if (config_wr) begin
            st_next.cfg = i_reg_wdata;
        end
        st_next.cd_a_prev = i_card_detect_line_a;
        st_next.cd_b_prev = i_card_detect_line_b;
        st_next.ready_prev = i_ready_line;
        st_next.primed = 1'b1;
        st_next.rdata = sscf_pkg::RDATA_IDLE;
        if (status_rd) begin
            st_next.rdata = {sscf_pkg::RESERVED_BITS_VALUE,
                             visible(st_reg.flags, st_reg.cfg, is_io)};
        end else if (config_rd) begin
            st_next.rdata = st_reg.cfg;
        end
        st_next.irq = |visible(st_next.flags, st_next.cfg, is_io);
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg.cfg <= sscf_pkg::CONFIG_RESET;
            st_reg.flags <= sscf_pkg::STATUS_RESET[sscf_pkg::SOURCE_MSB:0];
            st_reg.cd_a_prev <= 1'b0;
            st_reg.cd_b_prev <= 1'b0;
            st_reg.ready_prev <= 1'b0;
            st_reg.primed <= 1'b0;
            st_reg.rdata <= sscf_pkg::RDATA_IDLE;
            st_reg.irq <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_reg_rdata = st_reg.rdata;
    assign o_socket_status_event = st_reg.irq;
    assign o_status_irq_route_select = st_reg.cfg.status_irq_route_select;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    masked_read_zero_a: assert property (
        (status_rd && !st_reg.cfg.card_detect_irq_enable) |=> !o_reg_rdata[3])
        else $error("masked card detect flag read as one");
    flag_sets_a: assert property (
        (st_reg.primed && st_reg.cfg.card_detect_irq_enable &&
         (i_card_detect_line_a != st_reg.cd_a_prev)) |=> st_reg.flags.card_detect_changed)
        else $error("enabled card detect change did not set flag");
    read_clears_a: assert property (
        (status_rd && !i_flag_clear_on_write && !i_ring_function_enable &&
         !i_card_status_change_pin) |=> !st_reg.flags.battery_dead_flag)
        else $error("read did not clear flag");
    write_one_clears_a: assert property (
        (status_wr && i_flag_clear_on_write && i_reg_wdata[3] && st_reg.primed &&
         i_card_detect_line_a == st_reg.cd_a_prev &&
         i_card_detect_line_b == st_reg.cd_b_prev) |=> !st_reg.flags.card_detect_changed)
        else $error("write of one did not clear flag");
    reserved_zero_a: assert property (
        status_rd |=> (o_reg_rdata[7:4] == 4'h0))
        else $error("reserved status bits not zero");
    io_ready_zero_a: assert property (
        (status_rd && i_socket_card_kind) |=> (o_reg_rdata[2:1] == 2'b00))
        else $error("io card ready or battery flag read as one");
    ready_edge_a: assert property (
        (st_reg.primed && st_reg.cfg.ready_irq_enable && !i_socket_card_kind &&
         $rose(i_ready_line)) |=> st_reg.flags.ready_rise_flag)
        else $error("ready rise not flagged");
    ring_level_a: assert property (
        (i_ring_function_enable && st_reg.cfg.battery_dead_irq_enable) |=>
        (st_reg.flags.battery_dead_flag == $past(i_ring_indicate_line)))
        else $error("ring mode bit does not follow ring line");
    irq_follows_a: assert property (
        o_socket_status_event ==
        (|visible(st_reg.flags, st_reg.cfg, $past(i_socket_card_kind))))
        else $error("interrupt does not match enabled flags");
    ready_masked_a: assert property (
        (status_rd && !st_reg.cfg.ready_irq_enable) |=> !o_reg_rdata[sscf_pkg::READY_BIT])
        else $error("masked ready flag read as one");
    low_masked_a: assert property (
        (status_rd && !st_reg.cfg.battery_low_irq_enable) |=>
        !o_reg_rdata[sscf_pkg::BATTERY_LOW_BIT])
        else $error("masked battery low flag read as one");
    dead_masked_a: assert property (
        (status_rd && !st_reg.cfg.battery_dead_irq_enable) |=>
        !o_reg_rdata[sscf_pkg::BATTERY_DEAD_BIT])
        else $error("masked battery dead flag read as one");
    detect_b_sets_a: assert property (
        (st_reg.primed && st_reg.cfg.card_detect_irq_enable &&
         (i_card_detect_line_b != st_reg.cd_b_prev)) |=> st_reg.flags.card_detect_changed)
        else $error("enabled second card detect change did not set flag");
    detect_quiet_a: assert property (
        (!st_reg.flags.card_detect_changed && i_card_detect_line_a == st_reg.cd_a_prev &&
         i_card_detect_line_b == st_reg.cd_b_prev) |=> !st_reg.flags.card_detect_changed)
        else $error("card detect flag set with no line change");
    low_sets_a: assert property (
        (st_reg.cfg.battery_low_irq_enable && !i_socket_card_kind && i_battery_low_line) |=>
        st_reg.flags.battery_low_flag)
        else $error("battery low warning not flagged");
    dead_sets_a: assert property (
        (st_reg.cfg.battery_dead_irq_enable && !i_ring_function_enable &&
         i_card_status_change_pin) |=> st_reg.flags.battery_dead_flag)
        else $error("status change input not flagged");
    io_no_set_a: assert property (
        (i_socket_card_kind && !st_reg.flags.ready_rise_flag) |=>
        !st_reg.flags.ready_rise_flag)
        else $error("io card set the ready flag");
    read_keeps_a: assert property (
        (status_rd && i_flag_clear_on_write && !status_wr && !i_ring_function_enable &&
         st_reg.flags.battery_dead_flag) |=> st_reg.flags.battery_dead_flag)
        else $error("status read cleared flag in write-one mode");
    irq_on_flag_a: assert property (
        (st_reg.flags.card_detect_changed && st_reg.cfg.card_detect_irq_enable) |->
        o_socket_status_event)
        else $error("enabled flag set but no interrupt");
    irq_drops_a: assert property (
        !(|st_reg.flags) |-> !o_socket_status_event)
        else $error("interrupt high with all flags clear");
    config_readback_a: assert property (
        config_rd |=> (o_reg_rdata == $past(st_reg.cfg)))
        else $error("config register did not read back");
    route_write_a: assert property (
        config_wr |=> (o_status_irq_route_select == $past(i_reg_wdata[7:4])))
        else $error("route select not written");
endmodule
`default_nettype wire

// ---- sscf_card_model.sv ----
`default_nettype none
module sscf_card_model (
    output logic o_card_detect_line_a,
    output logic o_card_detect_line_b,
    output logic o_ready_line,
    output logic o_battery_low_line,
    output logic o_card_status_change_pin,
    output logic o_ring_indicate_line,
    input wire logic i_clk_sys
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // card lines, idle low
    // ----------------------------------------
    // lines only move just after a rising edge, so the socket never sees a mid-cycle change
    logic [5:0] lines = 6'h00;
    assign {o_ring_indicate_line, o_card_detect_line_a, o_card_detect_line_b} = lines[5:3];
    assign {o_ready_line, o_battery_low_line, o_card_status_change_pin} = lines[2:0];
    task automatic set_line(input int idx, input logic val);
        @(posedge i_clk_sys);
        lines[idx] <= val;
    endtask
    task automatic pulse(input int idx);
        set_line(idx, 1'b1);
        set_line(idx, 1'b0);
    endtask
endmodule
`default_nettype wire

// ---- sscf_socket_status_change_flags_test.sv ----
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module sscf_socket_status_change_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, clr_w = 1'b0, kind = 1'b0, ring = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic irq;
    logic [3:0] route;
    logic cd_a, cd_b, rdy, bat, stc, ri;
    int err_total = 0;
    int check_count = 0;
    sscf_card_model card (.i_clk_sys(clk), .o_card_detect_line_a(cd_a),
        .o_card_detect_line_b(cd_b), .o_ready_line(rdy), .o_battery_low_line(bat),
        .o_card_status_change_pin(stc), .o_ring_indicate_line(ri));
    sscf_socket_status_change_flags uut (.i_clk_sys(clk), .i_resetn(rstn), .i_reg_addr(addr),
        .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_flag_clear_on_write(clr_w),
        .i_socket_card_kind(kind), .i_ring_function_enable(ring), .i_card_detect_line_a(cd_a),
        .i_card_detect_line_b(cd_b), .i_ready_line(rdy), .i_battery_low_line(bat),
        .i_card_status_change_pin(stc), .i_ring_indicate_line(ri), .o_reg_rdata(rdata),
        .o_socket_status_event(irq), .o_status_irq_route_select(route));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK("read data", exp, rdata)
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    // hard stop in case a task never returns
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(12'h804, 8'h00);
        rd_chk(12'h805, 8'h00);
        rd_chk(12'h806, 8'h00);
        `CHK("route", 4'h0, route)
        wr_reg(12'h805, 8'ha8);
        rd_chk(12'h805, 8'ha8);
        `CHK("route", 4'ha, route)
        card.pulse(2);
        settle(3);
        rd_chk(12'h804, 8'h00);
        `CHK("irq", 1'b0, irq)
        card.set_line(4, 1'b1);
        settle(3);
        `CHK("irq", 1'b1, irq)
        rd_chk(12'h804, 8'h08);
        rd_chk(12'h804, 8'h00);
        settle(2);
        `CHK("irq", 1'b0, irq)
        card.set_line(3, 1'b1);
        settle(3);
        rd_chk(12'h804, 8'h08);
        $display("test masking and card detect done");
        wr_reg(12'h805, 8'h07);
        for (int i = 0; i < 3; i++) begin
            card.pulse(i);
            settle(3);
            rd_chk(12'h804, 8'h01 << i);
            rd_chk(12'h804, 8'h00);
        end
        $display("test sources done");
        @(posedge clk) clr_w <= 1'b1;
        card.pulse(0);
        settle(3);
        rd_chk(12'h804, 8'h01);
        rd_chk(12'h804, 8'h01);
        wr_reg(12'h804, 8'hf0);
        rd_chk(12'h804, 8'h01);
        wr_reg(12'h804, 8'hff);
        rd_chk(12'h804, 8'h00);
        $display("test write-one clear done");
        card.pulse(1);
        settle(3);
        @(posedge clk) kind <= 1'b1;
        card.pulse(2);
        card.pulse(1);
        settle(3);
        rd_chk(12'h804, 8'h00);
        `CHK("irq", 1'b0, irq)
        @(posedge clk) ring <= 1'b1;
        card.set_line(5, 1'b1);
        settle(3);
        rd_chk(12'h804, 8'h01);
        card.set_line(5, 1'b0);
        settle(3);
        rd_chk(12'h804, 8'h00);
        $display("test io card and ring done");
        @(posedge clk) rstn <= 1'b0;
        kind <= 1'b0;
        ring <= 1'b0;
        settle(2);
        @(posedge clk) rstn <= 1'b1;
        rd_chk(12'h805, 8'h00);
        `CHK("route", 4'h0, route)
        wr_reg(12'h805, 8'h0f);
        rd_chk(12'h804, 8'h00);
        `CHK("irq", 1'b0, irq)
        $display("test mid-run reset done");
        finish_test();
    end
endmodule
`default_nettype wire
